// [shared/xor_dp_pkg.sv]
// Package: encodings, field positions and phase codes of the exclusive-OR datapath
package xor_dp_pkg;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  // Opcode fields, upper bits of the instruction word
  localparam logic [5:0] XOR_LITERAL_OPC = 6'h3a;
  localparam logic [5:0] XOR_FILE_OPC = 6'h06;
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int LIT_HI = 7;
  localparam int ADDR_HI = 6;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  typedef enum logic [1:0] {
    PH_DECODE = 2'b00,
    PH_READ = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE = 2'b11
  } phase_e;
endpackage

// [src/xor_unit.sv]
// Combinational exclusive-OR with zero detect
`timescale 1ns/1ps
module xor_unit
  import xor_dp_pkg::*;
(
  input wire logic [DATA_W-1:0] a,
  input wire logic [DATA_W-1:0] b,
  output logic [DATA_W-1:0] y,
  output logic zero
);
  always_comb begin
    y = a ^ b;
    zero = (y == ZERO_BYTE);
  end
endmodule

// [src/xor_instruction_datapath.sv]
// Four-phase execution datapath for the two exclusive-OR instructions
`timescale 1ns/1ps
module xor_instruction_datapath
  import xor_dp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic insn_valid,
  input wire logic [INSN_W-1:0] insn,
  input wire logic [DATA_W-1:0] file_rdata,
  output logic [ADDR_W-1:0] file_addr,
  output logic file_rd,
  output logic file_we,
  output logic [DATA_W-1:0] file_wdata,
  output logic [DATA_W-1:0] w_reg,
  output logic zero_flag,
  output logic zero_we,
  output logic busy,
  output logic done
);
  // ************************************************
  // Phase sequencer and datapath state
  // ************************************************
  typedef enum logic [1:0] {
    K_NONE = 2'b00,
    K_LIT = 2'b01,
    K_FILE = 2'b10
  } kind_e;

  phase_e phase_r, phase_nxt;
  kind_e kind_r, kind_nxt;
  logic busy_r, busy_nxt;
  logic dest_r, dest_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] opnd_r, opnd_nxt;
  logic [DATA_W-1:0] res_r, res_nxt;
  logic [DATA_W-1:0] w_r, w_nxt;
  logic zf_r, zf_nxt;
  logic zwe_r, zwe_nxt;
  logic rd_r, rd_nxt;
  logic we_r, we_nxt;
  logic done_r, done_nxt;
  logic [DATA_W-1:0] xo;
  logic xz;
  logic take_lit;
  logic take_file;

  // ************************************************
  // Decode helpers
  // ************************************************
  // Opcode match on the upper field of the instruction word
  function automatic logic opcode_is(
    input logic [INSN_W-1:0] word,
    input logic [OPC_HI-OPC_LO:0] opc
  );
    return word[OPC_HI:OPC_LO] == opc;
  endfunction

  // Result lands in the working register unless the file form asks for write-back
  function automatic logic dest_is_w(
    input kind_e kind,
    input logic dest
  );
    return (kind == K_LIT) || !dest;
  endfunction

  // Result lands in the file register only for the file form with write-back
  function automatic logic dest_is_file(
    input kind_e kind,
    input logic dest
  );
    return (kind == K_FILE) && dest;
  endfunction

  // ************************************************
  // Instruction acceptance
  // ************************************************
  // Unknown opcodes are ignored; only this block's two instructions start a cycle
  always_comb begin
    take_lit = insn_valid && !busy_r && opcode_is(insn, XOR_LITERAL_OPC);
    take_file = insn_valid && !busy_r && opcode_is(insn, XOR_FILE_OPC);
  end

  xor_unit xor_unit_inst (
    .a(w_r),
    .b(opnd_r),
    .y(xo),
    .zero(xz)
  );

  // ************************************************
  // Phase sequencer
  // ************************************************
  always_comb begin
    phase_nxt = phase_r;
    kind_nxt = kind_r;
    busy_nxt = busy_r;
    dest_nxt = dest_r;
    addr_nxt = addr_r;
    case (phase_r)
      PH_DECODE: begin
        if (take_lit) begin
          kind_nxt = K_LIT;
          busy_nxt = 1'b1;
          phase_nxt = PH_READ;
        end else if (take_file) begin
          kind_nxt = K_FILE;
          dest_nxt = insn[DEST_BIT];
          addr_nxt = insn[ADDR_HI:0];
          busy_nxt = 1'b1;
          phase_nxt = PH_READ;
        end
      end
      PH_READ: begin
        phase_nxt = PH_PROCESS;
      end
      PH_PROCESS: begin
        phase_nxt = PH_WRITE;
      end
      PH_WRITE: begin
        kind_nxt = K_NONE;
        busy_nxt = 1'b0;
        phase_nxt = PH_DECODE;
      end
      default: begin
        phase_nxt = PH_DECODE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= PH_DECODE;
      kind_r <= K_NONE;
      busy_r <= 1'b0;
      dest_r <= 1'b0;
      addr_r <= '0;
    end else begin
      phase_r <= phase_nxt;
      kind_r <= kind_nxt;
      busy_r <= busy_nxt;
      dest_r <= dest_nxt;
      addr_r <= addr_nxt;
    end
  end

  // ************************************************
  // Operand, result and working register
  // ************************************************
  // File data is taken at the end of the read strobe cycle, so the store must answer
  // within that cycle; a slower store would need a wait phase that this block lacks
  always_comb begin
    opnd_nxt = opnd_r;
    res_nxt = res_r;
    w_nxt = w_r;
    zf_nxt = zf_r;
    case (phase_r)
      PH_DECODE: begin
        if (take_lit) begin
          opnd_nxt = insn[LIT_HI:0];
        end
      end
      PH_READ: begin
        if (kind_r == K_FILE) begin
          opnd_nxt = file_rdata;
        end
      end
      PH_PROCESS: begin
        res_nxt = xo;
        zf_nxt = xz;
      end
      PH_WRITE: begin
        if (dest_is_w(kind_r, dest_r)) begin
          w_nxt = res_r;
        end
      end
      default: begin
        opnd_nxt = opnd_r;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      opnd_r <= ZERO_BYTE;
      res_r <= ZERO_BYTE;
      w_r <= W_RESET;
      zf_r <= 1'b0;
    end else begin
      opnd_r <= opnd_nxt;
      res_r <= res_nxt;
      w_r <= w_nxt;
      zf_r <= zf_nxt;
    end
  end

  // ************************************************
  // One-cycle strobes
  // ************************************************
  always_comb begin
    rd_nxt = 1'b0;
    zwe_nxt = 1'b0;
    we_nxt = 1'b0;
    done_nxt = 1'b0;
    case (phase_r)
      PH_DECODE: begin
        rd_nxt = take_file;
      end
      PH_PROCESS: begin
        zwe_nxt = 1'b1;
        we_nxt = dest_is_file(kind_r, dest_r);
      end
      PH_WRITE: begin
        done_nxt = 1'b1;
      end
      default: begin
        done_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_r <= 1'b0;
      zwe_r <= 1'b0;
      we_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      rd_r <= rd_nxt;
      zwe_r <= zwe_nxt;
      we_r <= we_nxt;
      done_r <= done_nxt;
    end
  end

  // ************************************************
  // Outputs, each straight from its register
  // ************************************************
  always_comb begin
    file_addr = addr_r;
    file_rd = rd_r;
    file_we = we_r;
    file_wdata = res_r;
    w_reg = w_r;
    zero_flag = zf_r;
    zero_we = zwe_r;
    busy = busy_r;
    done = done_r;
  end
endmodule

// [verification/xor_dp_asserts.sv]
// Port checker
`timescale 1ns/1ps
module xor_dp_asserts
  import xor_dp_pkg::*;
(
  input logic mclk, reset_n, insn_valid, file_rd, file_we, zero_flag, zero_we, busy, done,
  input logic [INSN_W-1:0] insn,
  input logic [ADDR_W-1:0] file_addr,
  input logic [DATA_W-1:0] file_rdata, file_wdata, w_reg
);
  wire lit = insn_valid && !busy && insn[OPC_HI:OPC_LO] == XOR_LITERAL_OPC;
  wire fil = insn_valid && !busy && insn[OPC_HI:OPC_LO] == XOR_FILE_OPC;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  lit_xor_a: assert property (lit |-> ##4
    w_reg == ($past(w_reg, 4) ^ $past(insn[7:0], 4))) else $error("lit");
  file_to_w_a: assert property (fil && !insn[DEST_BIT] |-> ##1 file_rd
    && file_addr == $past(insn[6:0]) ##3 w_reg == ($past(w_reg, 4) ^ $past(file_rdata, 3)))
    else $error("file to w");
  file_back_a: assert property (fil && insn[DEST_BIT] |-> ##3 file_we
    && file_wdata == ($past(w_reg, 3) ^ $past(file_rdata, 2))) else $error("write back");
  read_strobe_a: assert property (fil |=> file_rd ##1 !file_rd)
    else $error("read strobe");
  ignored_word_a: assert property (insn_valid && !busy && !lit && !fil
    |=> !busy && !file_rd) else $error("ignored word");
  four_phase_a: assert property (lit || fil |=> (busy && !done) [*2]
    ##1 busy && zero_we ##1 done && !busy) else $error("phases");
  zero_flag_a: assert property (zero_we |=> zero_flag ==
    ($past(file_we) ? file_wdata == 8'h00 : w_reg == 8'h00)) else $error("zero");
endmodule
bind xor_instruction_datapath xor_dp_asserts chk (.*);

// [verification/xor_instruction_datapath_tb.sv]
// Random bench
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t %h %h", $time, g, e); end end
module xor_instruction_datapath_tb;
  import xor_dp_pkg::*;
  logic mclk = 1'b0, reset_n = 1'b0, insn_valid = 1'b0;
  logic [INSN_W-1:0] insn = 14'h0000;
  logic [DATA_W-1:0] w = W_RESET, file_rdata = 8'h00, file_wdata, w_reg, k, r, e;
  logic [ADDR_W-1:0] file_addr;
  logic file_rd, file_we, zero_flag, zero_we, busy, done;
  int n_fail = 0, compares = 0, kd;
  xor_instruction_datapath xor_instruction_datapath_inst (.*);
  // Expected result: literal form uses the literal, file form the byte read
  function automatic logic [DATA_W-1:0] expect_result(input int kind,
    input logic [DATA_W-1:0] w_old, lit, rd);
    return w_old ^ (kind == 0 ? lit : rd);
  endfunction
  task finish_test;
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial forever #4 mclk = ~mclk;
  initial begin
    #20000 n_fail++;
    finish_test;
  end
  initial begin
    void'($urandom(32'h8cd28ac7));
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      if (i == 30) begin
        @(posedge mclk);
        reset_n <= 1'b0;
        @(posedge mclk);
        #1 `CHK(w_reg, W_RESET)
        `CHK(zero_flag, 1'b0)
        `CHK({busy, done, file_rd, file_we, zero_we}, 5'h00)
        @(posedge mclk);
        reset_n <= 1'b1;
        w = W_RESET;
      end
      kd = i == 0 ? 0 : i == 1 ? 2 : $urandom_range(3);
      k = i == 0 ? 8'h00 : 8'($urandom);
      r = i == 1 ? w : 8'($urandom);
      @(posedge mclk);
      insn_valid <= 1'b1;
      file_rdata <= r;
      insn <= kd == 0 ? {XOR_LITERAL_OPC, k} : kd == 3 ? {6'h3f, k} :
        {XOR_FILE_OPC, kd == 2, k[6:0]};
      @(posedge mclk);
      insn_valid <= 1'b0;
      #1 `CHK(file_rd, kd == 1 || kd == 2)
      if (kd == 1 || kd == 2) `CHK(file_addr, k[6:0])
      @(posedge mclk);
      // Stale data after the read cycle must not reach the result
      file_rdata <= ~r;
      @(posedge mclk);
      #1 `CHK(file_we, kd == 2)
      `CHK(zero_we, kd != 3)
      @(posedge mclk);
      #1 `CHK(done, kd != 3)
      if (kd != 3) begin
        e = expect_result(kd, w, k, r);
        `CHK(zero_flag, e == 8'h00)
        if (kd == 2) `CHK(file_wdata, e)
        else w = e;
      end
      `CHK(w_reg, w)
    end
    finish_test;
  end
endmodule
